/* File: hdl/bridge_secondary_status_windows.sv */
// Purpose: Secondary status bits and memory forwarding windows of one bridge port
// Assumes: Event inputs are one-cycle pulses synchronous to clk
// Notes: Forwarding decisions are registered, one cycle after txn_valid
`timescale 1ns/10ps

// Behaviour
// RL1: Capability and timing status bits read zero
// RL2: Requester parity error sets master parity bit
// RL3: Master parity bit never set without enable
// RL4: Completer abort sent sets signaled abort bit
// RL5: Completer abort received sets received abort
// RL6: Unsupported request received sets master abort
// RL7: Error message with SERR enable sets bit
// RL8: Poisoned packet received sets detected parity bit
// RL9: Memory bottom writable bits 31:20, low zeros
// RL10: Memory top writable bits 31:20, low ones
// RL11: Inclusive memory window decides forwarding
// RL12: Prefetch low nibbles read one, 64-bit
// RL13: Prefetch bottom bits 31:20 plus upper word
// RL14: Prefetch top bits 31:20 plus upper word
// RL15: Prefetch window decides read/write forwarding
// RL16: Parity response control enables poison reporting
// RL17: Upper prefetch bottom word, resets zero
// RL18: Write one clears; set beats clear; abort bits 27:29 ignore writes and clear only on reset
// RL19: Reserved fields read zero, ignore writes
module bridge_secondary_status_windows
  import bridge_win_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ev_sec_parity_err,
  input wire logic ev_sec_abort_sent,
  input wire logic ev_sec_abort_rcvd,
  input wire logic ev_sec_unsup_rcvd,
  input wire logic ev_err_msg_sent,
  input wire logic ev_sec_poisoned_rcvd,
  input wire logic txn_valid,
  input wire logic [63:0] txn_addr,
  input wire logic txn_from_primary,
  output logic fwd_valid,
  output logic mem_hit,
  output logic pref_hit,
  output logic fwd_claim,
  output logic parity_resp_en,
  output logic serr_en
);
  generate
    if (ADDR_W < 8) begin : g_bad
      $error("bridge_secondary_status_windows: ADDR_W must be at least 8");
    end
  endgenerate

  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_go;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] mem_win;
  logic [31:0] pref_win;
  logic [31:0] pref_base_hi;
  logic [31:0] pref_top_hi;
  logic [31:0] bridge_ctrl;
  logic [NUM_EVENTS-1:0] sticky;
  logic mem_in;
  logic pref_in;
  logic wr_err;
  logic rd_err;
  logic [31:0] rd_data;

  // Word decode shared by the read and write paths
  function automatic logic [NUM_REGS-1:0] decode(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    decode = '0;
    lo = {a[7:2], 2'h0};
    if ((a >> 8) == '0) begin
      unique case (lo)
        OFS_SEC_STATUS: decode[SEL_STATUS] = 1'b1;
        OFS_MEM_WIN: decode[SEL_MEM] = 1'b1;
        OFS_PREF_WIN: decode[SEL_PREF] = 1'b1;
        OFS_PREF_BASE_HI: decode[SEL_PREF_BASE_HI] = 1'b1;
        OFS_PREF_TOP_HI: decode[SEL_PREF_TOP_HI] = 1'b1;
        OFS_BRIDGE_CTRL: decode[SEL_BRIDGE_CTRL] = 1'b1;
        default: decode = '0;
      endcase
    end
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    merge = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = new_word[8*i +: 8];
      end
    end
  endfunction

  // Only sticky bits appear; everything else in the word is zero
  function automatic logic [31:0] status_image(input logic [NUM_EVENTS-1:0] s);
    status_image = WORD_ZERO;
    for (int i = 0; i < NUM_EVENTS; i++) begin
      status_image[EV_POS[i]] = s[i];
    end
  endfunction

  axil_reg_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clk(clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_go(wr_go),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_go(rd_go),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  wire [NUM_REGS-1:0] wr_dec = decode(wr_addr);
  wire [NUM_REGS-1:0] rd_dec = decode(rd_addr);
  wire [NUM_REGS-1:0] wr_sel = wr_go ? wr_dec : '0;
  assign wr_err = ~|wr_dec;
  assign rd_err = ~|rd_dec;

  // Masks drop reserved and read-only bits so they never store
  wire [31:0] next_mem_win = wr_sel[SEL_MEM] ?
    (merge(mem_win, wr_data, wr_strb) & MEM_WIN_WMASK) : mem_win; // RL9 RL10 RL19
  wire [31:0] next_pref_win = wr_sel[SEL_PREF] ?
    (merge(pref_win, wr_data, wr_strb) & PREF_WIN_WMASK) : pref_win; // RL13 RL14
  wire [31:0] next_pref_base_hi = wr_sel[SEL_PREF_BASE_HI] ?
    merge(pref_base_hi, wr_data, wr_strb) : pref_base_hi; // RL17
  wire [31:0] next_pref_top_hi = wr_sel[SEL_PREF_TOP_HI] ?
    merge(pref_top_hi, wr_data, wr_strb) : pref_top_hi;
  wire [31:0] next_bridge_ctrl = wr_sel[SEL_BRIDGE_CTRL] ?
    (merge(bridge_ctrl, wr_data, wr_strb) & BRIDGE_CTRL_WMASK) : bridge_ctrl;

  wire perr_resp = bridge_ctrl[BIT_PERR_RESP];
  wire serr_enable = bridge_ctrl[BIT_SERR_EN];

  wire [NUM_EVENTS-1:0] ev_set;
  wire [NUM_EVENTS-1:0] ev_clr;
  wire [NUM_EVENTS-1:0] next_sticky;

  assign ev_set[EV_MASTER_PARITY] = ev_sec_parity_err & perr_resp; // RL2 RL3 RL16
  assign ev_set[EV_SIG_TGT_ABORT] = ev_sec_abort_sent; // RL4
  assign ev_set[EV_RCV_TGT_ABORT] = ev_sec_abort_rcvd; // RL5
  assign ev_set[EV_RCV_MST_ABORT] = ev_sec_unsup_rcvd; // RL6
  assign ev_set[EV_RCV_SYS_ERR] = ev_err_msg_sent & serr_enable; // RL7
  assign ev_set[EV_DET_PARITY] = ev_sec_poisoned_rcvd; // RL8

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_ev
      // Abort bits are read-only and only reset clears them
      assign ev_clr[gi] = EV_W1C[gi] & wr_sel[SEL_STATUS] &
        wr_strb[EV_POS[gi] / 8] & wr_data[EV_POS[gi]]; // RL18
      assign next_sticky[gi] = ev_set[gi] | (sticky[gi] & ~ev_clr[gi]); // RL18
    end
  endgenerate

  wire [31:0] status_word = status_image(sticky); // RL1 RL19
  wire [31:0] pref_word = pref_win | PREF_WIN_RO; // RL12

  assign rd_data =
    ({32{rd_dec[SEL_STATUS]}} & status_word) |
    ({32{rd_dec[SEL_MEM]}} & mem_win) |
    ({32{rd_dec[SEL_PREF]}} & pref_word) |
    ({32{rd_dec[SEL_PREF_BASE_HI]}} & pref_base_hi) |
    ({32{rd_dec[SEL_PREF_TOP_HI]}} & pref_top_hi) |
    ({32{rd_dec[SEL_BRIDGE_CTRL]}} & bridge_ctrl);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_win <= WORD_ZERO;
      pref_win <= WORD_ZERO;
      pref_base_hi <= WORD_ZERO;
      pref_top_hi <= WORD_ZERO;
      bridge_ctrl <= WORD_ZERO;
    end else begin
      mem_win <= next_mem_win;
      pref_win <= next_pref_win;
      pref_base_hi <= next_pref_base_hi;
      pref_top_hi <= next_pref_top_hi;
      bridge_ctrl <= next_bridge_ctrl;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sticky <= '0;
    end else begin
      sticky <= next_sticky;
    end
  end

  // Window bounds from the 12-bit fields and their implied low bits
  wire [31:0] mem_bottom = {mem_win[BASE_LSB +: FIELD_W], LOW_ZERO}; // RL9
  wire [31:0] mem_top = {mem_win[TOP_LSB +: FIELD_W], LOW_ONES}; // RL10
  wire [63:0] pref_bottom = {pref_base_hi, pref_win[BASE_LSB +: FIELD_W], LOW_ZERO}; // RL13
  wire [63:0] pref_top = {pref_top_hi, pref_win[TOP_LSB +: FIELD_W], LOW_ONES}; // RL14

  addr_window_match #(
    .AW(32)
  ) u_mem_match (
    .addr(txn_addr[31:0]),
    .bottom(mem_bottom),
    .top(mem_top),
    .hit(mem_in)
  );

  addr_window_match #(
    .AW(64)
  ) u_pref_match (
    .addr(txn_addr),
    .bottom(pref_bottom),
    .top(pref_top),
    .hit(pref_in)
  );

  // The non-prefetch window only covers the low 4 GB
  wire mem_match = mem_in & (txn_addr[63:32] == 32'h0000_0000); // RL11
  wire any_match = mem_match | pref_in; // RL15
  // Downstream traffic is claimed inside the windows, upstream outside
  wire claim = txn_from_primary ? any_match : ~any_match;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      mem_hit <= 1'b0;
      pref_hit <= 1'b0;
      fwd_claim <= 1'b0;
    end else begin
      fwd_valid <= txn_valid;
      mem_hit <= txn_valid & mem_match; // RL11
      pref_hit <= txn_valid & pref_in; // RL15
      fwd_claim <= txn_valid & claim;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parity_resp_en <= 1'b0;
      serr_en <= 1'b0;
    end else begin
      parity_resp_en <= next_bridge_ctrl[BIT_PERR_RESP]; // RL16
      serr_en <= next_bridge_ctrl[BIT_SERR_EN];
    end
  end
endmodule

/* File: hdl/bridge_win_pkg.sv */
// Purpose: Shared constants for the secondary status and memory window bank
// Assumes: 32-bit register words on AXI4-Lite, byte addresses as offsets
// Notes: Window fields carry address bits 31:20 only
package bridge_win_pkg;
  localparam logic [7:0] OFS_SEC_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MEM_WIN = 8'h20;
  localparam logic [7:0] OFS_PREF_WIN = 8'h24;
  localparam logic [7:0] OFS_PREF_BASE_HI = 8'h28;
  localparam logic [7:0] OFS_PREF_TOP_HI = 8'h2c;
  localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h3c;

  localparam int NUM_REGS = 6;
  localparam int SEL_STATUS = 0;
  localparam int SEL_MEM = 1;
  localparam int SEL_PREF = 2;
  localparam int SEL_PREF_BASE_HI = 3;
  localparam int SEL_PREF_TOP_HI = 4;
  localparam int SEL_BRIDGE_CTRL = 5;

  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] MEM_WIN_WMASK = 32'hfff0_fff0;
  localparam logic [31:0] PREF_WIN_WMASK = 32'hfff0_fff0;
  localparam logic [31:0] PREF_WIN_RO = 32'h0001_0001;
  localparam logic [31:0] BRIDGE_CTRL_WMASK = 32'h0003_0000;
  localparam int BIT_PERR_RESP = 16;
  localparam int BIT_SERR_EN = 17;

  localparam int FIELD_W = 12;
  localparam int BASE_LSB = 4;
  localparam int TOP_LSB = 20;
  localparam logic [19:0] LOW_ZERO = 20'h0_0000;
  localparam logic [19:0] LOW_ONES = 20'hf_ffff;

  localparam int NUM_EVENTS = 6;
  localparam int EV_MASTER_PARITY = 0;
  localparam int EV_SIG_TGT_ABORT = 1;
  localparam int EV_RCV_TGT_ABORT = 2;
  localparam int EV_RCV_MST_ABORT = 3;
  localparam int EV_RCV_SYS_ERR = 4;
  localparam int EV_DET_PARITY = 5;
  localparam int EV_POS [NUM_EVENTS] = '{24, 27, 28, 29, 30, 31};
  localparam logic [NUM_EVENTS-1:0] EV_W1C = 6'h31;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hdl/addr_window_match.sv */
// Purpose: Inclusive bottom/top address compare for one forwarding window
// Assumes: Bottom above top gives an empty window
// Notes: Purely combinational, caller registers the result
`timescale 1ns/10ps
module addr_window_match #(
  parameter int AW = 32
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] bottom,
  input wire logic [AW-1:0] top,
  output logic hit
);
  generate
    if (AW < 1) begin : g_bad
      $error("addr_window_match: AW must be positive");
    end
  endgenerate

  wire above_bottom = (addr >= bottom);
  wire below_top = (addr <= top);

  assign hit = above_bottom & below_top;
endmodule

/* File: hdl/axil_reg_slave.sv */
// Purpose: AXI4-Lite slave front end issuing one-cycle register strobes
// Assumes: One write and one read outstanding at most
// Notes: Ready outputs reopen only after the response handshake
`timescale 1ns/10ps
module axil_reg_slave
  import bridge_win_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_go,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_go,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_held;
  logic w_held;
  logic ar_held;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire b_done = s_axi_bvalid & s_axi_bready;
  wire r_done = s_axi_rvalid & s_axi_rready;

  // Address and data may arrive in either order
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign rd_go = ar_held & ~s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (aw_fire) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (b_done) begin
      s_axi_awready <= 1'b1;
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_held <= 1'b0;
      wr_data <= WORD_ZERO;
      wr_strb <= 4'h0;
    end else if (w_fire) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (b_done) begin
      s_axi_wready <= 1'b1;
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      ar_held <= 1'b0;
      rd_addr <= '0;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      ar_held <= 1'b1;
      rd_addr <= s_axi_araddr;
    end else if (rd_go) begin
      ar_held <= 1'b0;
    end else if (r_done) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: tb/win_sva.sv */
// Purpose: Port checks for the status and window bank
// Assumes: Bench offers write address and data together
// Notes: Bound into the design top
`timescale 1ns/10ps
module win_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic txn_valid,
  input wire logic [63:0] txn_addr,
  input wire logic txn_from_primary,
  input wire logic fwd_valid,
  input wire logic mem_hit,
  input wire logic pref_hit,
  input wire logic fwd_claim
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] rd_ofs;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ofs <= 8'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_ofs <= s_axi_araddr[7:0];
    end
  end
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_resp_s;
    !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence rd_resp_s;
    !s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  fwd_delay_a: assert property (fwd_valid == $past(txn_valid))
    else $error("forward strobe late");
  hit_qual_a: assert property ((mem_hit || pref_hit) |-> fwd_valid)
    else $error("hit without strobe");
  mem_low_a: assert property (txn_valid && txn_addr[63:32] != 32'h0 |=> !mem_hit)
    else $error("memory hit above 4G");
  claim_dir_a: assert property (fwd_claim ==
    (fwd_valid && ($past(txn_from_primary) == (mem_hit || pref_hit))))
    else $error("claim direction wrong");
  status_zero_a: assert property (s_axi_rvalid && rd_ofs == 8'h1c |->
    (s_axi_rdata & 32'h06ff_ffff) == 32'h0) else $error("status fixed bits set");
  mem_rsvd_a: assert property (s_axi_rvalid && rd_ofs == 8'h20 |->
    (s_axi_rdata & 32'h000f_000f) == 32'h0) else $error("memory reserved bits set");
  pref_cap_a: assert property (s_axi_rvalid && rd_ofs == 8'h24 |->
    (s_axi_rdata & 32'h000f_000f) == 32'h0001_0001) else $error("prefetch nibbles wrong");
  wr_answer_a: assert property (wr_taken_s |=> wr_resp_s)
    else $error("write answer timing");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> rd_resp_s)
    else $error("read answer timing");
endmodule
bind bridge_secondary_status_windows win_sva #(.ADDR_W(ADDR_W)) sva_u (.*);

/* File: tb/far_side_model.sv */
// Purpose: Link partners feeding events and transactions
// Assumes: Bench commands last one cycle
// Notes: Idle address shows its inverse, never a held value
`timescale 1ns/10ps
module far_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] ev_cmd,
  input wire logic txn_cmd,
  input wire logic dir_cmd,
  input wire logic [63:0] addr_cmd,
  output logic ev_sec_parity_err,
  output logic ev_sec_abort_sent,
  output logic ev_sec_abort_rcvd,
  output logic ev_sec_unsup_rcvd,
  output logic ev_err_msg_sent,
  output logic ev_sec_poisoned_rcvd,
  output logic txn_valid,
  output logic [63:0] txn_addr,
  output logic txn_from_primary
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ev_sec_poisoned_rcvd, ev_err_msg_sent, ev_sec_unsup_rcvd} <= 3'h0;
      {ev_sec_abort_rcvd, ev_sec_abort_sent, ev_sec_parity_err} <= 3'h0;
      txn_valid <= 1'h0;
      txn_addr <= 64'h0;
      txn_from_primary <= 1'h0;
    end else begin
      {ev_sec_poisoned_rcvd, ev_err_msg_sent, ev_sec_unsup_rcvd} <= ev_cmd[5:3];
      {ev_sec_abort_rcvd, ev_sec_abort_sent, ev_sec_parity_err} <= ev_cmd[2:0];
      txn_valid <= txn_cmd;
      txn_addr <= txn_cmd ? addr_cmd : ~txn_addr;
      txn_from_primary <= txn_cmd ? dir_cmd : ~txn_from_primary;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Purpose: Random and corner stimulus for the status and window bank
// Assumes: Far side model retimes commands by one cycle
// Notes: Expected values come from bench functions, the win task and fixed constants
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, txn_cmd = 1'h0, dir_cmd = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ev_sec_parity_err, ev_sec_abort_sent, ev_sec_abort_rcvd, ev_sec_unsup_rcvd;
  logic ev_err_msg_sent, ev_sec_poisoned_rcvd, txn_valid, txn_from_primary;
  logic fwd_valid, mem_hit, pref_hit, fwd_claim, parity_resp_en, serr_en;
  logic [63:0] txn_addr, addr_cmd = 64'h0;
  logic [5:0] ev_cmd = 6'h0;
  logic [31:0] seed = 32'h29;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  bridge_secondary_status_windows dut_u (.*);
  far_side_model far_u (.*);
  always #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] reg_exp(input logic [7:0] a, input logic [31:0] d);
    case (a)
      8'h20: return d & 32'hfff0_fff0;
      8'h24: return (d & 32'hfff0_fff0) | 32'h0001_0001;
      8'h28, 8'h2c: return d;
      8'h3c: return d & 32'h0003_0000;
      default: return 32'h0;
    endcase
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic ev_pulse(input logic [5:0] e);
    ev_cmd <= e;
    @(posedge clk);
    ev_cmd <= 6'h0;
    repeat (2) @(posedge clk);
  endtask
  // Result fixed at two edges after the command, so no wait loop here
  task automatic win(input logic [63:0] a, mb, mt, pb, pt);
    logic m, p;
    logic [31:0] v;
    m = a >= mb && a <= mt;
    p = a >= pb && a <= pt;
    v = rnd();
    addr_cmd <= a;
    dir_cmd <= v[0];
    txn_cmd <= 1'h1;
    @(posedge clk);
    txn_cmd <= 1'h0;
    repeat (2) @(posedge clk);
    chk("window", {28'h0, fwd_valid, mem_hit, pref_hit, fwd_claim},
      {28'h0, 1'h1, m, p, v[0] == (m | p)});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    logic [31:0] v, w, d, hb, ht;
    logic [1:0] r;
    logic [7:0] regs [6];
    logic [63:0] mb, mt, pb, pt;
    logic [63:0] pts [10];
    regs = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h3c};
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    foreach (regs[i]) begin
      axr(regs[i], d, r);
      chk("reset value", d, reg_exp(regs[i], 32'h0));
    end
    repeat (4) begin
      foreach (regs[i]) begin
        v = rnd();
        axw(regs[i], v, r);
        chk("write resp", {30'h0, r}, 32'h0);
        axr(regs[i], d, r);
        chk("read resp", {30'h0, r}, 32'h0);
        chk("read back", d, reg_exp(regs[i], v));
      end
    end
    chk("ctrl outputs", {30'h0, serr_en, parity_resp_en}, {30'h0, v[17:16]});
    axw(8'h30, rnd(), r);
    chk("unmapped write", {30'h0, r}, 32'h2);
    axr(8'h30, d, r);
    chk("unmapped read", d, 32'h0);
    chk("unmapped rresp", {30'h0, r}, 32'h2);
    axw(8'h28, 32'h0, r);
    s_axi_wstrb <= 4'h5;
    axw(8'h28, 32'hffff_ffff, r);
    s_axi_wstrb <= 4'hf;
    axr(8'h28, d, r);
    chk("byte lanes", d, 32'h00ff_00ff);
    axw(8'h3c, 32'h0, r);
    ev_pulse(6'h3f);
    axr(8'h1c, d, r);
    chk("status gated", d, 32'hb800_0000);
    axw(8'h3c, 32'h0003_0000, r);
    chk("ctrl set", {30'h0, serr_en, parity_resp_en}, 32'h3);
    ev_pulse(6'h11);
    axr(8'h1c, d, r);
    chk("status enabled", d, 32'hf900_0000);
    axw(8'h1c, 32'h4100_0000, r);
    axr(8'h1c, d, r);
    chk("clear some", d, 32'hb800_0000);
    axw(8'h1c, 32'hffff_ffff, r);
    axr(8'h1c, d, r);
    chk("clear all", d, 32'h3800_0000);
    // Poison lands on the same edge as the clear
    fork
      axw(8'h1c, 32'h8000_0000, r);
      ev_pulse(6'h20);
    join
    axr(8'h1c, d, r);
    chk("set beats clear", d, 32'hb800_0000);
    repeat (6) begin
      v = rnd();
      w = rnd();
      hb = rnd() & 32'h3;
      ht = hb + (rnd() & 32'h1);
      axw(8'h20, v, r);
      axw(8'h24, w, r);
      axw(8'h28, hb, r);
      axw(8'h2c, ht, r);
      mb = {32'h0, v[15:4], 20'h0};
      mt = {32'h0, v[31:20], 20'hf_ffff};
      pb = {hb, w[15:4], 20'h0};
      pt = {ht, w[31:20], 20'hf_ffff};
      pts = '{mb, mb - 64'h1, mt, mt + 64'h1, pb, pb - 64'h1, pt, pt + 64'h1,
        mb | 64'h1_0000_0000, {rnd() & 32'h3, rnd()}};
      foreach (pts[k]) begin
        win(pts[k], mb, mt, pb, pt);
      end
    end
    close_out();
  end
endmodule
